// ===== core/pll_cal_and_counter_sync_control.sv
// Lock detect, oscillator calibration trigger and counter alignment control
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1: Lock detection runs by default; bit 3 set stops it and clears the flag.
// RULE2: Calibration clock is reference divided by 2, 4, 8 or 16 per selector.
// RULE3: Host picks divide 2/4 below 12.5 MHz, 8 below 50 MHz, 16 anywhere.
// RULE4: Default divide-by-16 gives slowest calibration clock, longest calibration.
// RULE5: Calibration starts only on active calibrate-now 0 to 1; bit resets to 0.
// RULE6: Host writes 0 and strobes update, then writes 1 and strobes again.
// RULE7: Host keeps oscillator output divider static during calibration.
// RULE8: Alignment pin: 00/11 nothing, 01 asynchronous, 10 synchronous counter reset.
// RULE9: Lock flagged after 5, 16, 64 or 255 consecutive in-window comparisons.
// RULE10: Rising active bit on update gives one start pulse; no restart while 1.
module pll_cal_and_counter_sync_control #(
    parameter logic [9:0] CAL_TICKS = pll_ctl_pkg::CAL_TICKS_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [9:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    input wire logic [9:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic cmp_edge_pin,
    input wire logic in_window_pin,
    input wire logic align_pin,
    output logic digital_lock_flag,
    output logic cal_clk_en,
    output logic cal_busy,
    output logic cal_start,
    output logic counters_rst_level,
    output logic counters_rst_pulse
);
    ////////////////////////////////////////////////////////////////////////////
    // Buffer and active registers
    pll_ctl_pkg::ldcal_t ldcal_buf_r;
    pll_ctl_pkg::ldcal_t ldcal_act_r;
    pll_ctl_pkg::sync_ctl_t sync_buf_r;
    pll_ctl_pkg::sync_ctl_t sync_act_r;
    logic update;
    logic prev_cal_now_r;

    assign update = wr_en && (wr_addr == pll_ctl_pkg::ADDR_UPDATE)
        && wr_data[pll_ctl_pkg::UPDATE_BIT];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ldcal_buf_r <= pll_ctl_pkg::LDCAL_RST; // [RULE5]
            sync_buf_r <= pll_ctl_pkg::SYNC_RST;
        end else if (wr_en) begin
            if (wr_addr == pll_ctl_pkg::ADDR_LDCAL) begin
                ldcal_buf_r <= wr_data;
            end else if (wr_addr == pll_ctl_pkg::ADDR_SYNC) begin
                sync_buf_r <= wr_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ldcal_act_r <= pll_ctl_pkg::LDCAL_RST; // [RULE4] [RULE5]
            sync_act_r <= pll_ctl_pkg::SYNC_RST;
            prev_cal_now_r <= 1'b0;
        end else if (update) begin
            ldcal_act_r <= ldcal_buf_r;
            sync_act_r <= sync_buf_r;
            prev_cal_now_r <= ldcal_act_r.cal_now;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= pll_ctl_pkg::RD_UNMAPPED;
        end else if (rd_en) begin
            if (rd_addr == pll_ctl_pkg::ADDR_LDCAL) begin
                rd_data <= ldcal_act_r;
            end else if (rd_addr == pll_ctl_pkg::ADDR_SYNC) begin
                rd_data <= sync_act_r;
            end else begin
                rd_data <= pll_ctl_pkg::RD_UNMAPPED;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration start and duration
    logic start_pend_r;
    logic [9:0] cal_cnt_r;

    // Flag set one cycle after the update that made the active bit rise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            start_pend_r <= 1'b0;
        end else begin
            start_pend_r <= update && !ldcal_act_r.cal_now && ldcal_buf_r.cal_now; // [RULE10]
        end
    end

    assign cal_start = start_pend_r; // [RULE5] [RULE10]

    cal_clock_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .div_sel(ldcal_act_r.cal_div_sel), // [RULE2]
        .tick(cal_clk_en)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cal_cnt_r <= 10'h000;
        end else if (cal_start) begin
            cal_cnt_r <= CAL_TICKS;
        end else if (cal_clk_en && cal_cnt_r != 10'h000) begin
            cal_cnt_r <= cal_cnt_r - 10'h001; // [RULE4]
        end
    end

    assign cal_busy = (cal_cnt_r != 10'h000);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] cmp_s_r;
    logic [1:0] win_s_r;
    logic [1:0] align_s_r;
    logic cmp_d_r;
    logic align_d_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmp_s_r <= 2'h0;
            win_s_r <= 2'h0;
            align_s_r <= 2'h0;
            cmp_d_r <= 1'b0;
            align_d_r <= 1'b0;
        end else begin
            cmp_s_r <= {cmp_s_r[0], cmp_edge_pin};
            win_s_r <= {win_s_r[0], in_window_pin};
            align_s_r <= {align_s_r[0], align_pin};
            cmp_d_r <= cmp_s_r[1];
            align_d_r <= align_s_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Digital lock detection
    logic cmp_cycle;
    logic [7:0] lock_cnt_r;
    logic lock_r;

    assign cmp_cycle = cmp_s_r[1] && !cmp_d_r;

    always_ff @(posedge clk) begin
        if (!rst_n || ldcal_act_r.ld_disable) begin
            lock_cnt_r <= 8'h00; // [RULE1]
            lock_r <= 1'b0;
        end else if (cmp_cycle) begin
            if (!win_s_r[1]) begin
                lock_cnt_r <= 8'h00; // [RULE9]
                lock_r <= 1'b0;
            end else if (lock_cnt_r < pll_ctl_pkg::lock_need(ldcal_act_r.lock_cnt_sel)) begin
                lock_cnt_r <= lock_cnt_r + 8'h01;
                if (lock_cnt_r + 8'h01 >= pll_ctl_pkg::lock_need(ldcal_act_r.lock_cnt_sel)) begin
                    lock_r <= 1'b1; // [RULE9]
                end
            end else begin
                lock_r <= 1'b1;
            end
        end
    end

    assign digital_lock_flag = lock_r;

    ////////////////////////////////////////////////////////////////////////////
    // Counter alignment on the alignment pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            counters_rst_level <= 1'b0;
            counters_rst_pulse <= 1'b0;
        end else begin
            counters_rst_level <= align_s_r[1]
                && sync_act_r.sync_mode == pll_ctl_pkg::SYNC_ASYNC; // [RULE8]
            counters_rst_pulse <= align_s_r[1] && !align_d_r
                && sync_act_r.sync_mode == pll_ctl_pkg::SYNC_SYNC; // [RULE8]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    start_on_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        cal_start |-> $past(update) && $past(ldcal_buf_r.cal_now)
            && !$past(ldcal_act_r.cal_now)) // [RULE5]
        else $error("calibration start without rising active bit");
    no_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
        update && ldcal_act_r.cal_now |=> !cal_start) // [RULE10]
        else $error("calibration restarted while bit held at one");
    start_single_a: assert property (@(posedge clk) disable iff (!rst_n)
        cal_start |=> !cal_start) // [RULE10]
        else $error("start pulse longer than one cycle");
    busy_after_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        cal_start |=> cal_busy && cal_cnt_r == CAL_TICKS) // [RULE5]
        else $error("calibration not running after start");
    lock_off_disabled_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(ldcal_act_r.ld_disable) |-> !digital_lock_flag) // [RULE1]
        else $error("lock flag while detection disabled");
    lock_needs_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(digital_lock_flag) |->
            lock_cnt_r >= pll_ctl_pkg::lock_need($past(ldcal_act_r.lock_cnt_sel))) // [RULE9]
        else $error("lock flagged before enough comparison cycles");
    lock_loss_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmp_cycle && !win_s_r[1] |=> !digital_lock_flag && lock_cnt_r == 8'h00) // [RULE9]
        else $error("lock kept after out-of-window comparison");
    align_async_a: assert property (@(posedge clk) disable iff (!rst_n)
        align_s_r[1] && sync_act_r.sync_mode == pll_ctl_pkg::SYNC_ASYNC
            && !update |=> counters_rst_level) // [RULE8]
        else $error("asynchronous counter reset missing");
    align_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sync_act_r.sync_mode == pll_ctl_pkg::SYNC_NONE || sync_act_r.sync_mode == 2'h3)
            && !update |=> !counters_rst_level && !counters_rst_pulse) // [RULE8]
        else $error("counter reset in no-action mode");
    div16_default_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> ldcal_act_r.cal_div_sel == pll_ctl_pkg::DIV_BY_16) // [RULE4]
        else $error("calibration divider not defaulting to sixteen");

    cal_seen_c: cover property (@(posedge clk) disable iff (!rst_n) cal_start ##1 cal_busy[*3]);
    lock_seen_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(digital_lock_flag));
    sync_pulse_c: cover property (@(posedge clk) disable iff (!rst_n) counters_rst_pulse);
    async_rst_c: cover property (@(posedge clk) disable iff (!rst_n) counters_rst_level);
endmodule : pll_cal_and_counter_sync_control

// ===== core/pll_ctl_pkg.sv
// Shared constants, field layouts and helpers for the loop control block
package pll_ctl_pkg;
    localparam logic [9:0] ADDR_LDCAL = 10'h018;
    localparam logic [9:0] ADDR_SYNC = 10'h019;
    localparam logic [9:0] ADDR_UPDATE = 10'h232;
    localparam int UPDATE_BIT = 0;
    localparam logic [7:0] LDCAL_RST = 8'h06;
    localparam logic [7:0] SYNC_RST = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    localparam logic [1:0] SYNC_NONE = 2'h0;
    localparam logic [1:0] SYNC_ASYNC = 2'h1;
    localparam logic [1:0] SYNC_SYNC = 2'h2;
    localparam logic [1:0] DIV_BY_16 = 2'h3;
    localparam logic [7:0] LOCK_CNT_5 = 8'h05;
    localparam logic [7:0] LOCK_CNT_16 = 8'h10;
    localparam logic [7:0] LOCK_CNT_64 = 8'h40;
    localparam logic [7:0] LOCK_CNT_255 = 8'hFF;
    localparam logic [9:0] CAL_TICKS_DEF = 10'h040;

    typedef struct packed {
        logic cmos_dc_offset;
        logic [1:0] lock_cnt_sel;
        logic ld_window;
        logic ld_disable;
        logic [1:0] cal_div_sel;
        logic cal_now;
    } ldcal_t;

    typedef struct packed {
        logic [1:0] sync_mode;
        logic [2:0] r_delay;
        logic [2:0] n_delay;
    } sync_ctl_t;

    // Last count value of the calibration clock divider: 1, 3, 7 or 15, for periods of 2, 4, 8 or 16 cycles
    function automatic logic [3:0] div_last(input logic [1:0] sel);
        case (sel)
            2'h0: div_last = 4'h1;
            2'h1: div_last = 4'h3;
            2'h2: div_last = 4'h7;
            default: div_last = 4'hF;
        endcase
    endfunction : div_last

    // Consecutive in-window comparison cycles needed before lock
    function automatic logic [7:0] lock_need(input logic [1:0] sel);
        case (sel)
            2'h0: lock_need = LOCK_CNT_5;
            2'h1: lock_need = LOCK_CNT_16;
            2'h2: lock_need = LOCK_CNT_64;
            default: lock_need = LOCK_CNT_255;
        endcase
    endfunction : lock_need
endpackage : pll_ctl_pkg

// ===== core/cal_clock_divider.sv
// Calibration clock divider: one-cycle enable pulse every 2, 4, 8 or 16 clocks
`timescale 1ns/100ps
module cal_clock_divider (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] div_sel,
    output logic tick
);
    logic [3:0] cnt_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
        end else if (cnt_r >= pll_ctl_pkg::div_last(div_sel)) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    assign tick = (cnt_r == pll_ctl_pkg::div_last(div_sel)); // [RULE2] [RULE4]

    div_period_a: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> cnt_r == 4'h0 && !tick) // [RULE2]
        else $error("divider did not wrap after tick");
endmodule : cal_clock_divider

// ===== tb/host_ctl_model.sv
// Host controller model driving the register write and read strobes
`timescale 1ns/100ps
module host_ctl_model (
    input wire logic clk,
    output logic wr_en,
    output logic [9:0] wr_addr,
    output logic [7:0] wr_data,
    output logic rd_en,
    output logic [9:0] rd_addr
);
    initial begin
        wr_en = 1'b0;
        wr_addr = 10'h000;
        wr_data = 8'h00;
        rd_en = 1'b0;
        rd_addr = 10'h000;
    end

    // Released bus shows inverted values so nothing stale passes
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask : wr

    task automatic rd(input logic [9:0] a);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        rd_addr <= ~a;
    endtask : rd

    // Zero then one, each committed; divider and other fields taken from the caller's base
    // Oscillator output divider is never written here
    task automatic calibrate(input logic [7:0] base);
        wr(pll_ctl_pkg::ADDR_LDCAL, base & 8'hFE);
        wr(pll_ctl_pkg::ADDR_UPDATE, 8'h01);
        wr(pll_ctl_pkg::ADDR_LDCAL, base | 8'h01);
        wr(pll_ctl_pkg::ADDR_UPDATE, 8'h01);
    endtask : calibrate
endmodule : host_ctl_model

// ===== tb/pll_cal_and_counter_sync_control_tb.sv
// Self-checking bench for the loop control block
`timescale 1ns/100ps
module pll_cal_and_counter_sync_control_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_en, rd_en, lock, cal_en, busy, start, lvl, pul, rd_seen;
    logic [9:0] wr_addr, rd_addr;
    logic [7:0] rd_data, wr_data;
    logic cmp_pin = 1'b0;
    logic win_pin = 1'b0;
    logic align_pin = 1'b0;
    logic [7:0] exp_q[$];
    logic [31:0] rnd = 32'h9F82;
    int bad_count = 0;
    int check_count = 0;
    int starts = 0;
    int pulses = 0;
    int levels = 0;
    int n;
    int dur[2];
    int need[4] = '{5, 16, 64, 255};

    always #12.5 clk = ~clk;

    host_ctl_model host_ctl_model_inst (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr));
    pll_cal_and_counter_sync_control #(.CAL_TICKS(10'h004)) pll_cal_and_counter_sync_control_inst (
        .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .cmp_edge_pin(cmp_pin),
        .in_window_pin(win_pin), .align_pin(align_pin), .digital_lock_flag(lock),
        .cal_clk_en(cal_en), .cal_busy(busy), .cal_start(start),
        .counters_rst_level(lvl), .counters_rst_pulse(pul));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_int(input int got, input int exp);
        check_val(8'(got), 8'(exp));
    endtask : check_int

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_ctl_model_inst.rd(a);
    endtask : rd_chk

    task automatic set_reg(input logic [9:0] a, input logic [7:0] d);
        host_ctl_model_inst.wr(a, d);
        host_ctl_model_inst.wr(pll_ctl_pkg::ADDR_UPDATE, 8'h01);
        repeat (20) @(negedge clk);
    endtask : set_reg

    task automatic wait_en(output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (cal_en !== 1'b1 && k < 40);
        if (k >= 40) begin
            bad_count++;
            summarize();
        end
    endtask : wait_en

    task automatic cmp(input int k);
        repeat (k) begin
            rnd = lfsr(rnd);
            @(posedge clk) cmp_pin <= 1'b1;
            repeat (2) @(posedge clk);
            cmp_pin <= 1'b0;
            repeat (3 + rnd[1:0]) @(posedge clk);
        end
        repeat (4) @(negedge clk);
    endtask : cmp

    ////////////////////////////////////////////////////////////////////////////
    // Read results are taken off the queue one cycle after the strobe
    always @(posedge clk) begin
        starts += int'(start === 1'b1);
        pulses += int'(pul === 1'b1);
        levels += int'(lvl === 1'b1);
        if (rd_seen === 1'b1) begin
            check_val(rd_data, exp_q.pop_front());
        end
        rd_seen = rd_en;
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(pll_ctl_pkg::ADDR_LDCAL, 8'h06);
        rd_chk(pll_ctl_pkg::ADDR_UPDATE, 8'h00);
        rd_chk(10'h3FF, 8'h00);
        host_ctl_model_inst.wr(pll_ctl_pkg::ADDR_SYNC, 8'h40);
        rd_chk(pll_ctl_pkg::ADDR_SYNC, 8'h00);
        for (int s = 0; s < 4; s++) begin
            set_reg(pll_ctl_pkg::ADDR_LDCAL, 8'(2 * s));
            wait_en(n);
            wait_en(n);
            check_int(n, 2 << s);
        end
        for (int s = 0; s < 4; s += 3) begin
            starts = 0;
            host_ctl_model_inst.calibrate(8'(2 * s));
            repeat (2) @(negedge clk);
            check_int(starts, 1);
            host_ctl_model_inst.wr(pll_ctl_pkg::ADDR_UPDATE, 8'h01);
            n = 0;
            while (busy === 1'b1 && n < 2000) begin
                @(negedge clk);
                n++;
            end
            if (n >= 2000) begin
                bad_count++;
                summarize();
            end
            check_val({7'h00, busy}, 8'h00);
            check_int(starts, 1);
            dur[s / 3] = n;
        end
        check_int(int'(dur[1] > dur[0]), 1);
        for (int s = 0; s < 4; s++) begin
            set_reg(pll_ctl_pkg::ADDR_LDCAL, 8'(32 * s + 6));
            @(posedge clk) win_pin <= 1'b0;
            cmp(1);
            @(posedge clk) win_pin <= 1'b1;
            cmp(need[s] - 1);
            check_val({7'h00, lock}, 8'h00);
            cmp(1);
            check_val({7'h00, lock}, 8'h01);
        end
        set_reg(pll_ctl_pkg::ADDR_LDCAL, 8'h0E);
        cmp(6);
        check_val({7'h00, lock}, 8'h00);
        set_reg(pll_ctl_pkg::ADDR_LDCAL, 8'h06);
        cmp(5);
        check_val({7'h00, lock}, 8'h01);
        @(posedge clk) win_pin <= 1'b0;
        cmp(1);
        check_val({7'h00, lock}, 8'h00);
        for (int m = 0; m < 4; m++) begin
            rnd = lfsr(rnd);
            set_reg(pll_ctl_pkg::ADDR_SYNC, {2'(m), rnd[5:0]});
            rd_chk(pll_ctl_pkg::ADDR_SYNC, {2'(m), rnd[5:0]});
            repeat (2) @(negedge clk);
            levels = 0;
            pulses = 0;
            @(posedge clk) align_pin <= 1'b1;
            repeat (8) @(posedge clk);
            align_pin <= 1'b0;
            repeat (8) @(negedge clk);
            check_int(pulses, int'(m == 2));
            check_int(levels, 8 * int'(m == 1));
        end
        summarize();
    end
endmodule : pll_cal_and_counter_sync_control_tb
